//--- hw/cbst_regs.sv
// Purpose: Balance switch control, expiry registers and balance elapsed timer behind APB
// Assumes: pclk at 20 MHz; APB master holds each request until pready
// Notes: One wait state on every access; writes commit at the pready edge
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module cbst_regs #(
  parameter longint SEC_CYCLES = cbst_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbst_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Balancing switch drive and status
  output logic [cbst_pkg::CELLS-1:0] switch_close,
  output logic balance_active
);
  localparam logic [cbst_pkg::PRE_W-1:0] PRE_LAST = cbst_pkg::PRE_W'(SEC_CYCLES - 1);

  function automatic cbst_pkg::cbst_unit_t unit_of(input logic [cbst_pkg::MODE_W-1:0] m);
    unique case (m)
      cbst_pkg::MODE_MANUAL_MIN: unit_of = cbst_pkg::UNIT_MIN;
      cbst_pkg::MODE_INDIV_HR: unit_of = cbst_pkg::UNIT_HR;
      cbst_pkg::MODE_GROUP_MIN: unit_of = cbst_pkg::UNIT_MIN;
      default: unit_of = cbst_pkg::UNIT_SEC;
    endcase
  endfunction

  function automatic logic is_done(input logic [cbst_pkg::EXP_W-1:0] lim, input logic [cbst_pkg::EXP_W-1:0] t);
    is_done = (lim == cbst_pkg::EXP_EXPIRED) || ((lim != cbst_pkg::EXP_FOREVER) && (t >= lim));
  endfunction

  logic [cbst_pkg::MODE_W-1:0] mode_q, mode_d;
  logic [cbst_pkg::CELLS-1:0] swen_q, swen_d;
  logic [cbst_pkg::EXP_W-1:0] mexp_q, mexp_d;
  logic [cbst_pkg::EXP_W-1:0] cexp_q, cexp_d;
  logic [cbst_pkg::EXP_W-1:0] timer_q, timer_d;
  logic [cbst_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [5:0] sec_q, sec_d;
  logic [5:0] min_q, min_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [cbst_pkg::CELLS-1:0] switch_q, switch_d;
  logic active_q, active_d;

  logic acc_first, acc_commit, wr;
  logic mapped;
  logic manual, auto_mode, indiv;
  logic master_done, cell_done, all_done;
  logic restart, new_event, running;
  logic sec_tick, min_tick, hr_tick, unit_tick;
  logic [cbst_pkg::CELLS-1:0] done_mask;

  always_comb begin
    acc_first = psel && penable && !pready_q;
    acc_commit = psel && penable && pready_q;
    wr = acc_commit && pwrite;
    mapped = (paddr == cbst_pkg::ADDR_SWITCH_CTRL) || (paddr == cbst_pkg::ADDR_MASTER_EXP) ||
             (paddr == cbst_pkg::ADDR_CELL_EXP_TWO) || (paddr == cbst_pkg::ADDR_BAL_CTRL) ||
             (paddr == cbst_pkg::ADDR_BAL_STATUS);
    manual = (mode_q == cbst_pkg::MODE_MANUAL_SEC) || (mode_q == cbst_pkg::MODE_MANUAL_MIN);
    auto_mode = mode_q[cbst_pkg::MODE_AUTO_BIT];
    indiv = auto_mode && mode_q[cbst_pkg::MODE_INDIV_BIT];
    master_done = is_done(mexp_q, timer_q);
    cell_done = is_done(cexp_q, timer_q);
    all_done = master_done && (!indiv || cell_done);
    running = (mode_q != cbst_pkg::MODE_OFF) && !all_done;
    // Restart only in manual mode and only before expiry; the bit itself is never stored
    restart = wr && (paddr == cbst_pkg::ADDR_SWITCH_CTRL) && pwdata[cbst_pkg::RESTART_BIT] &&
              manual && !master_done;
    new_event = wr && (paddr == cbst_pkg::ADDR_BAL_CTRL);
    sec_tick = running && (pre_q == PRE_LAST);
    min_tick = sec_tick && (sec_q == cbst_pkg::SUB_UNITS_LAST);
    hr_tick = min_tick && (min_q == cbst_pkg::SUB_UNITS_LAST);
    unique case (unit_of(mode_q))
      cbst_pkg::UNIT_MIN: unit_tick = min_tick;
      cbst_pkg::UNIT_HR: unit_tick = hr_tick;
      default: unit_tick = sec_tick;
    endcase
    for (int i = 0; i < cbst_pkg::CELLS; i++) begin
      done_mask[i] = (indiv && i == cbst_pkg::CELL_TWO_IDX) ? cell_done : master_done;
    end
  end

  // Register file writes
  always_comb begin
    mode_d = mode_q;
    swen_d = swen_q;
    mexp_d = mexp_q;
    cexp_d = cexp_q;
    if (wr) begin
      unique case (paddr)
        cbst_pkg::ADDR_SWITCH_CTRL: begin
          if (!(mode_q == cbst_pkg::MODE_DISCHARGE || auto_mode)) begin
            swen_d = pwdata[cbst_pkg::CELLS-1:0];
          end
        end
        cbst_pkg::ADDR_MASTER_EXP: begin
          if (mode_q == cbst_pkg::MODE_OFF) begin
            mexp_d = pwdata[cbst_pkg::EXP_W-1:0];
          end
        end
        cbst_pkg::ADDR_CELL_EXP_TWO: begin
          if (!auto_mode) begin
            cexp_d = pwdata[cbst_pkg::EXP_W-1:0];
          end
        end
        cbst_pkg::ADDR_BAL_CTRL: mode_d = pwdata[cbst_pkg::MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // Elapsed timer and its unit prescalers
  always_comb begin
    pre_d = pre_q;
    sec_d = sec_q;
    min_d = min_q;
    timer_d = timer_q;
    if (restart || new_event || mode_q == cbst_pkg::MODE_OFF) begin
      pre_d = '0;
      sec_d = '0;
      min_d = '0;
      timer_d = '0;
    end else if (running) begin
      pre_d = sec_tick ? '0 : pre_q + 1'b1;
      if (sec_tick) begin
        sec_d = min_tick ? 6'h00 : sec_q + 6'h01;
      end
      if (min_tick) begin
        min_d = hr_tick ? 6'h00 : min_q + 6'h01;
      end
      if (unit_tick && timer_q != cbst_pkg::EXP_FOREVER) begin
        timer_d = timer_q + 1'b1;
      end
    end
  end

  // Switch drive and bus answer
  always_comb begin
    switch_d = '0;
    if (mode_q != cbst_pkg::MODE_OFF) begin
      switch_d = swen_q & ~done_mask;
    end
    active_d = running;
    pready_d = acc_first;
    pslverr_d = acc_first && !mapped;
    prdata_d = prdata_q;
    if (acc_first) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        cbst_pkg::ADDR_SWITCH_CTRL: prdata_d[cbst_pkg::CELLS-1:0] = swen_q;
        cbst_pkg::ADDR_MASTER_EXP: prdata_d[cbst_pkg::EXP_W-1:0] = mexp_q;
        cbst_pkg::ADDR_CELL_EXP_TWO: prdata_d[cbst_pkg::EXP_W-1:0] = cexp_q;
        cbst_pkg::ADDR_BAL_CTRL: prdata_d[cbst_pkg::MODE_W-1:0] = mode_q;
        cbst_pkg::ADDR_BAL_STATUS: begin
          prdata_d[cbst_pkg::EXP_W-1:0] = timer_q;
          prdata_d[cbst_pkg::RUNNING_BIT] = running;
          prdata_d[cbst_pkg::EXPIRED_BIT] = all_done;
        end
        default: ;
      endcase
    end
  end

  // Register file state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= cbst_pkg::MODE_RESET;
      swen_q <= cbst_pkg::SWEN_RESET;
      mexp_q <= cbst_pkg::EXP_RESET;
      cexp_q <= cbst_pkg::EXP_RESET;
    end else begin
      mode_q <= mode_d;
      swen_q <= swen_d;
      mexp_q <= mexp_d;
      cexp_q <= cexp_d;
    end
  end

  // Elapsed timer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
      pre_q <= '0;
      sec_q <= '0;
      min_q <= '0;
    end else begin
      timer_q <= timer_d;
      pre_q <= pre_d;
      sec_q <= sec_d;
      min_q <= min_d;
    end
  end

  // Bus answer and switch drive state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      switch_q <= '0;
      active_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      switch_q <= switch_d;
      active_q <= active_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign switch_close = switch_q;
  assign balance_active = active_q;
endmodule

//--- hw/cbst_pkg.sv
// Purpose: Shared constants for the cell balance switch timer register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register offsets are word indices; the byte address is four times the index
package cbst_pkg;
  // Register indices and the word-aligned byte addresses derived from them
  localparam logic [9:0] IDX_SWITCH_CTRL = 10'h06f;
  localparam logic [9:0] IDX_MASTER_EXP = 10'h070;
  localparam logic [9:0] IDX_CELL_EXP_TWO = 10'h071;
  localparam logic [9:0] IDX_BAL_CTRL = 10'h07e;
  localparam logic [9:0] IDX_BAL_STATUS = 10'h07f;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH_CTRL = {IDX_SWITCH_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASTER_EXP = {IDX_MASTER_EXP, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CELL_EXP_TWO = {IDX_CELL_EXP_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_BAL_CTRL = {IDX_BAL_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_BAL_STATUS = {IDX_BAL_STATUS, 2'b00};

  // Field layout
  localparam int CELLS = 14;
  localparam int EXP_W = 10;
  localparam int MODE_W = 3;
  localparam int RESTART_BIT = 15;
  localparam int EXPIRED_BIT = 15;
  localparam int RUNNING_BIT = 14;
  localparam int CELL_TWO_IDX = 0;

  // Reset values
  localparam logic [EXP_W-1:0] EXP_RESET = 10'h000;
  localparam logic [CELLS-1:0] SWEN_RESET = 14'h0000;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

  // Special expiry codes
  localparam logic [EXP_W-1:0] EXP_FOREVER = 10'h3ff;
  localparam logic [EXP_W-1:0] EXP_EXPIRED = 10'h000;

  // Balance mode encodings
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_DISCHARGE = 3'h1;
  localparam logic [MODE_W-1:0] MODE_MANUAL_SEC = 3'h2;
  localparam logic [MODE_W-1:0] MODE_MANUAL_MIN = 3'h3;
  localparam logic [MODE_W-1:0] MODE_GROUP_MIN = 3'h5;
  localparam logic [MODE_W-1:0] MODE_INDIV_HR = 3'h7;
  localparam int MODE_AUTO_BIT = 2;
  localparam int MODE_INDIV_BIT = 1;

  // Time base
  localparam longint CLK_HZ = 20_000_000;
  localparam longint SECOND_S = 1;
  localparam longint SEC_CYCLES = CLK_HZ * SECOND_S;
  localparam int PRE_W = 25;
  localparam logic [5:0] SUB_UNITS_LAST = 6'h3b;

  typedef enum logic [1:0] {
    UNIT_SEC,
    UNIT_MIN,
    UNIT_HR
  } cbst_unit_t;
endpackage

//--- tb/cbst_regs_sva.sv
// Purpose: Assertions on the cbst_regs ports
// Assumes: Only accepted APB writes change the shadow state
// Notes: Shadows mirror mode, enables and both expiries
`timescale 1ns/1ps
module cbst_regs_sva #(
  parameter longint SEC_CYCLES = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbst_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Switch drive
  input wire logic [cbst_pkg::CELLS-1:0] switch_close,
  input wire logic balance_active
);
  logic [2:0] mode_q, mode_d;
  logic [13:0] en_q, en_d;
  logic [9:0] mx_q, mx_d, cx_q, cx_d;
  logic wr, rd;
  assign wr = psel && pready && pwrite;
  assign rd = psel && pready && !pwrite;
  always_comb begin
    mode_d = mode_q;
    en_d = en_q;
    mx_d = mx_q;
    cx_d = cx_q;
    if (wr && paddr == cbst_pkg::ADDR_BAL_CTRL) mode_d = pwdata[2:0];
    if (wr && paddr == cbst_pkg::ADDR_SWITCH_CTRL && mode_q != 3'h1 && !mode_q[2]) en_d = pwdata[13:0];
    if (wr && paddr == cbst_pkg::ADDR_MASTER_EXP && mode_q == 3'h0) mx_d = pwdata[9:0];
    if (wr && paddr == cbst_pkg::ADDR_CELL_EXP_TWO && !mode_q[2]) cx_d = pwdata[9:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
      en_q <= 14'h0000;
      mx_q <= 10'h000;
      cx_q <= 10'h000;
    end else begin
      mode_q <= mode_d;
      en_q <= en_d;
      mx_q <= mx_d;
      cx_q <= cx_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse after one wait state");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {12'h1bc, 12'h1c0, 12'h1c4, 12'h1f8, 12'h1fc}))
    else $error("pslverr does not match address map");
  a_switch_readback: assert property (rd && paddr == cbst_pkg::ADDR_SWITCH_CTRL |-> prdata == {18'h0_0000, en_q})
    else $error("switch control read back wrong");
  a_master_block: assert property (rd && paddr == cbst_pkg::ADDR_MASTER_EXP |-> prdata == {22'h00_0000, mx_q})
    else $error("master expiry read back wrong");
  a_cell_block: assert property (rd && paddr == cbst_pkg::ADDR_CELL_EXP_TWO |-> prdata == {22'h00_0000, cx_q})
    else $error("cell expiry read back wrong");
  a_switch_subset: assert property ((switch_close & ~(en_q | $past(en_q))) == 14'h0000)
    else $error("switch closed without its enable");
  a_zero_expired: assert property (mode_q inside {3'h1, 3'h2, 3'h3} && mx_q == 10'h000 |=> !balance_active)
    else $error("zero expiry still balancing");
  a_forever_runs: assert property ((mode_q inside {3'h2, 3'h3} && mx_q == 10'h3ff) [*2] |-> balance_active)
    else $error("indefinite expiry stopped");
  a_idle_open: assert property (!balance_active && $past(!balance_active) |-> switch_close == 14'h0000)
    else $error("switch closed while timer idle");
endmodule
bind cbst_regs cbst_regs_sva #(.SEC_CYCLES(SEC_CYCLES)) sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .switch_close(switch_close), .balance_active(balance_active));

//--- tb/cbst_regs_test.sv
// Purpose: Register and timer tests for cbst_regs over APB
// Assumes: SEC_CYCLES of 4 so one second is four clocks
// Notes: balance_active and switch_close are sampled on the falling edge; prdata and pslverr at the rising edge with pready
`timescale 1ns/1ps
module cbst_regs_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, balance_active;
  logic [13:0] switch_close, en;
  logic [9:0] mx, cx;
  int fail_count = 0, total_checks = 0, n;
  always #25 pclk = ~pclk;
  cbst_regs #(.SEC_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_close(switch_close), .balance_active(balance_active));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task outs(input logic act, input logic [13:0] sw);
    repeat (2) @(negedge pclk);
    chk({31'h0000_0000, balance_active}, {31'h0000_0000, act});
    chk({18'h0_0000, switch_close}, {18'h0_0000, sw});
  endtask
  initial begin
    en = 14'h0000;
    mx = 10'h000;
    cx = 10'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, cbst_pkg::ADDR_SWITCH_CTRL + 12'(4 * i), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'(m));
      apb(1'b1, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_8000 | (32'h0000_0011 << m));
      if (m != 1 && m < 4) en = 14'h0011 << m;
      apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0100 + 32'(m));
      if (m == 0) mx = 10'h100;
      apb(1'b1, cbst_pkg::ADDR_CELL_EXP_TWO, 32'h0000_0200 + 32'(m));
      if (m < 4) cx = 10'h200 + 10'(m);
      apb(1'b0, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_0000);
      chk(rd, {18'h0_0000, en});
      apb(1'b0, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0000);
      chk(rd, {22'h00_0000, mx});
      apb(1'b0, cbst_pkg::ADDR_CELL_EXP_TWO, 32'h0000_0000);
      chk(rd, {22'h00_0000, cx});
    end
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0003);
    apb(1'b1, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_2001);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'(cbst_pkg::MODE_MANUAL_SEC));
    outs(1'b1, 14'h2001);
    repeat (6) apb(1'b1, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_a001);
    outs(1'b1, 14'h2001);
    n = 0;
    while (balance_active === 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0000_0000, n >= 8 && n <= 14}, 32'h0000_0001);
    outs(1'b0, 14'h0000);
    apb(1'b1, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_a001);
    outs(1'b0, 14'h0000);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'(cbst_pkg::MODE_MANUAL_SEC));
    outs(1'b1, 14'h2001);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_03ff);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0002);
    repeat (30) @(negedge pclk);
    outs(1'b1, 14'h2001);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0002);
    outs(1'b0, 14'h0000);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0003);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'(cbst_pkg::MODE_DISCHARGE));
    repeat (3) apb(1'b1, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_a001);
    outs(1'b0, 14'h0000);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0001);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'(cbst_pkg::MODE_MANUAL_MIN));
    outs(1'b1, 14'h2001);
    repeat (230) @(negedge pclk);
    outs(1'b1, 14'h2001);
    repeat (6) @(negedge pclk);
    outs(1'b0, 14'h0000);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0000);
    apb(1'b1, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0003);
    apb(1'b1, cbst_pkg::ADDR_CELL_EXP_TWO, 32'h0000_0001);
    apb(1'b1, cbst_pkg::ADDR_BAL_CTRL, 32'h0000_0006);
    outs(1'b1, 14'h2001);
    repeat (2) @(negedge pclk);
    outs(1'b1, 14'h2000);
    repeat (6) @(negedge pclk);
    outs(1'b0, 14'h0000);
    apb(1'b0, cbst_pkg::ADDR_BAL_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_8003);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cbst_pkg::ADDR_SWITCH_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, cbst_pkg::ADDR_MASTER_EXP, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, cbst_pkg::ADDR_BAL_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_8000);
    outs(1'b0, 14'h0000);
    print_verdict();
  end
endmodule
